/* File: rtl/edge_event_controller.sv */
`timescale 1ns/1ps
`default_nettype none

// Function
// (R1) There are 37 edge lines, each able to raise an interrupt, an event and a wakeup.
// (R2) Each line picks rising, falling or both edges as its trigger.
// (R3) Each line has its own mask, and a masked edge raises no request.
// (R4) A pending bit per line records a selected edge and is readable by software.
// (R5) External edges are latched asynchronously so pulses shorter than a clock are caught.
// (R6) Sixteen external lines each pick their source among the general-purpose pins.
// (R7) The remaining lines are driven by wake-capable peripherals.
// (R8) Software clears a pending bit by writing one, which withdraws the request.
module edge_event_controller #(
	parameter int NUM_PINS = 83
) (
	input  wire logic                               clk_i,
	input  wire logic                               rst_i,
	input  wire eelc_pkg::wb_req_t                  wb_i,
	output var  eelc_pkg::wb_rsp_t                  wb_o,
	input  wire logic [NUM_PINS-1:0]                pin_i,
	input  wire logic [eelc_pkg::NUM_INT-1:0]       periph_i,
	output var  eelc_pkg::lines_t                   irq_req_o,
	output var  eelc_pkg::lines_t                   event_o,
	output var  logic                               wakeup_o,
	output var  logic                               irq_o
);

	eelc_pkg::lines_t                imr_q;
	eelc_pkg::lines_t                emr_q;
	eelc_pkg::lines_t                rise_q;
	eelc_pkg::lines_t                fall_q;
	eelc_pkg::lines_t                pend_q;
	eelc_pkg::lines_t                swt_q;
	eelc_pkg::lines_t                pend_clr;
	eelc_pkg::lines_t                rise_det;
	eelc_pkg::lines_t                fall_det;
	eelc_pkg::lines_t                trig;
	eelc_pkg::lines_t                level;
	logic [eelc_pkg::PSEL_W-1:0]     psel_q [eelc_pkg::NUM_EXT];
	logic [31:0]                     psel_word [4];
	logic [eelc_pkg::NUM_EXT-1:0]    ext_pin;
	logic [eelc_pkg::NUM_EXT-1:0]    ext_rise;
	logic [eelc_pkg::NUM_EXT-1:0]    ext_fall;
	logic [eelc_pkg::NUM_EXT-1:0]    ext_lvl;
	logic [eelc_pkg::NUM_INT-1:0]    int_q;
	eelc_pkg::wb_rsp_t               rsp_q;
	eelc_pkg::lines_t                irq_req_q;
	eelc_pkg::lines_t                event_q;
	logic                            wakeup_q;
	logic                            irq_q;
	logic                            req;
	logic                            wr;
	logic [31:0]                     rd_word;
	logic [31:0]                     bmask;
	logic [31:0]                     wr_word;
	logic [31:0]                     wr_ones;
	eelc_pkg::addr_t                 adr;

	assign adr     = wb_i.adr;
	assign req     = wb_i.cyc & wb_i.stb & ~rsp_q.ack;
	assign wr      = req & wb_i.we;
	assign bmask   = {{8{wb_i.sel[3]}}, {8{wb_i.sel[2]}}, {8{wb_i.sel[1]}}, {8{wb_i.sel[0]}}};
	assign wr_word = (rd_word & ~bmask) | (wb_i.dat & bmask);
	assign wr_ones = wb_i.dat & bmask;

	// External lines: pin selector and asynchronous edge capture
	for (genvar n = 0; n < eelc_pkg::NUM_EXT; n++) begin : g_ext
		localparam eelc_pkg::addr_t WADR = eelc_pkg::OFF_PSEL0 + eelc_pkg::addr_t'(4 * (n / 4));

		always_ff @(posedge clk_i) begin
			if (rst_i) begin
				psel_q[n] <= eelc_pkg::PSEL_RST;
			end else if (wr && adr == WADR && wb_i.sel[n % 4]) begin
				psel_q[n] <= wb_i.dat[8 * (n % 4) +: eelc_pkg::PSEL_W]; // R6
			end
		end

		// A source index past the last pin reads as a quiet low line
		assign ext_pin[n] = (32'(psel_q[n]) < NUM_PINS) ? pin_i[psel_q[n]] : 1'b0; // R6

		edge_catch u_catch (
			.clk_i   (clk_i),
			.rst_i   (rst_i),
			.pin_i   (ext_pin[n]),
			.rise_o  (ext_rise[n]),
			.fall_o  (ext_fall[n]),
			.level_o (ext_lvl[n])
		);
	end

	for (genvar g = 0; g < 4; g++) begin : g_pword
		assign psel_word[g] = {1'b0, psel_q[4 * g + 3], 1'b0, psel_q[4 * g + 2],
			1'b0, psel_q[4 * g + 1], 1'b0, psel_q[4 * g]};
	end

	// Internal peripheral lines are already in the clk_i domain
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			int_q <= '0;
		end else begin
			int_q <= periph_i; // R7
		end
	end

	assign rise_det = {periph_i & ~int_q, ext_rise}; // R7
	assign fall_det = {~periph_i & int_q, ext_fall}; // R7
	assign level    = {int_q, ext_lvl};

	// Both trigger bits set gives both edges
	assign trig = (rise_det & rise_q) | (fall_det & fall_q) | swt_q; // R2

	// Read mux, also the base for byte-lane merges
	always_comb begin
		rd_word = 32'h0000_0000;
		if (adr == eelc_pkg::OFF_IMR_LO) begin
			rd_word = imr_q[31:0];
		end else if (adr == eelc_pkg::OFF_IMR_HI) begin
			rd_word = 32'(imr_q[eelc_pkg::NUM_LINES-1:32]);
		end else if (adr == eelc_pkg::OFF_EMR_LO) begin
			rd_word = emr_q[31:0];
		end else if (adr == eelc_pkg::OFF_EMR_HI) begin
			rd_word = 32'(emr_q[eelc_pkg::NUM_LINES-1:32]);
		end else if (adr == eelc_pkg::OFF_RISE_LO) begin
			rd_word = rise_q[31:0];
		end else if (adr == eelc_pkg::OFF_RISE_HI) begin
			rd_word = 32'(rise_q[eelc_pkg::NUM_LINES-1:32]);
		end else if (adr == eelc_pkg::OFF_FALL_LO) begin
			rd_word = fall_q[31:0];
		end else if (adr == eelc_pkg::OFF_FALL_HI) begin
			rd_word = 32'(fall_q[eelc_pkg::NUM_LINES-1:32]);
		end else if (adr == eelc_pkg::OFF_PEND_LO) begin
			rd_word = pend_q[31:0]; // R4
		end else if (adr == eelc_pkg::OFF_PEND_HI) begin
			rd_word = 32'(pend_q[eelc_pkg::NUM_LINES-1:32]); // R4
		end else if (adr >= eelc_pkg::OFF_PSEL0 && adr <= eelc_pkg::OFF_PSEL3 && adr[1:0] == 2'h0) begin
			rd_word = psel_word[adr[3:2]];
		end else if (adr == eelc_pkg::OFF_LVL_LO) begin
			rd_word = level[31:0];
		end else if (adr == eelc_pkg::OFF_LVL_HI) begin
			rd_word = 32'(level[eelc_pkg::NUM_LINES-1:32]);
		end
	end

	// Classic slave: ack one cycle after the request, every address answered
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rsp_q <= '0;
		end else begin
			rsp_q.ack <= req;
			rsp_q.dat <= (req && !wb_i.we) ? rd_word : 32'h0000_0000;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			imr_q <= eelc_pkg::IMR_RST;
			emr_q <= eelc_pkg::EMR_RST;
		end else if (wr) begin
			if (adr == eelc_pkg::OFF_IMR_LO) begin
				imr_q[31:0] <= wr_word; // R3
			end else if (adr == eelc_pkg::OFF_IMR_HI) begin
				imr_q[eelc_pkg::NUM_LINES-1:32] <= wr_word[eelc_pkg::HI_W-1:0]; // R3
			end else if (adr == eelc_pkg::OFF_EMR_LO) begin
				emr_q[31:0] <= wr_word; // R3
			end else if (adr == eelc_pkg::OFF_EMR_HI) begin
				emr_q[eelc_pkg::NUM_LINES-1:32] <= wr_word[eelc_pkg::HI_W-1:0]; // R3
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rise_q <= eelc_pkg::RISE_RST;
			fall_q <= eelc_pkg::FALL_RST;
		end else if (wr) begin
			if (adr == eelc_pkg::OFF_RISE_LO) begin
				rise_q[31:0] <= wr_word; // R2
			end else if (adr == eelc_pkg::OFF_RISE_HI) begin
				rise_q[eelc_pkg::NUM_LINES-1:32] <= wr_word[eelc_pkg::HI_W-1:0]; // R2
			end else if (adr == eelc_pkg::OFF_FALL_LO) begin
				fall_q[31:0] <= wr_word; // R2
			end else if (adr == eelc_pkg::OFF_FALL_HI) begin
				fall_q[eelc_pkg::NUM_LINES-1:32] <= wr_word[eelc_pkg::HI_W-1:0]; // R2
			end
		end
	end

	// Software trigger is a one-cycle pulse per written one
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			swt_q <= '0;
		end else begin
			swt_q <= '0;
			if (wr && adr == eelc_pkg::OFF_SWT_LO) begin
				swt_q[31:0] <= wr_ones;
			end else if (wr && adr == eelc_pkg::OFF_SWT_HI) begin
				swt_q[eelc_pkg::NUM_LINES-1:32] <= wr_ones[eelc_pkg::HI_W-1:0];
			end
		end
	end

	always_comb begin
		pend_clr = '0;
		if (wr && adr == eelc_pkg::OFF_PEND_LO) begin
			pend_clr[31:0] = wr_ones; // R8
		end else if (wr && adr == eelc_pkg::OFF_PEND_HI) begin
			pend_clr[eelc_pkg::NUM_LINES-1:32] = wr_ones[eelc_pkg::HI_W-1:0]; // R8
		end
	end

	// A new edge in the clearing cycle stays pending
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pend_q <= eelc_pkg::PEND_RST;
		end else begin
			pend_q <= (pend_q & ~pend_clr) | (trig & imr_q); // R4
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_req_q <= '0;
			irq_q     <= 1'b0;
		end else begin
			irq_req_q <= pend_q & imr_q; // R3
			irq_q     <= |(pend_q & imr_q); // R1
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			event_q  <= '0;
			wakeup_q <= 1'b0;
		end else begin
			event_q  <= trig & emr_q; // R3
			wakeup_q <= |(pend_q & imr_q) | |(trig & emr_q); // R1
		end
	end

	assign wb_o      = rsp_q;
	assign irq_req_o = irq_req_q;
	assign event_o   = event_q;
	assign wakeup_o  = wakeup_q;
	assign irq_o     = irq_q;

endmodule

`default_nettype wire

/* File: rtl/eelc_pkg.sv */
package eelc_pkg;

	localparam int NUM_LINES = 37;
	localparam int NUM_EXT   = 16;
	localparam int NUM_INT   = NUM_LINES - NUM_EXT;
	localparam int HI_W      = NUM_LINES - 32;
	localparam int PSEL_W    = 7;
	localparam int ADDR_W    = 8;
	localparam int SYNC_LEN  = 3;

	typedef logic [ADDR_W-1:0]    addr_t;
	typedef logic [NUM_LINES-1:0] lines_t;

	// Register byte offsets
	localparam addr_t OFF_IMR_LO  = 8'h00;
	localparam addr_t OFF_IMR_HI  = 8'h04;
	localparam addr_t OFF_EMR_LO  = 8'h08;
	localparam addr_t OFF_EMR_HI  = 8'h0c;
	localparam addr_t OFF_RISE_LO = 8'h10;
	localparam addr_t OFF_RISE_HI = 8'h14;
	localparam addr_t OFF_FALL_LO = 8'h18;
	localparam addr_t OFF_FALL_HI = 8'h1c;
	localparam addr_t OFF_SWT_LO  = 8'h20;
	localparam addr_t OFF_SWT_HI  = 8'h24;
	localparam addr_t OFF_PEND_LO = 8'h28;
	localparam addr_t OFF_PEND_HI = 8'h2c;
	localparam addr_t OFF_PSEL0   = 8'h30;
	localparam addr_t OFF_PSEL3   = 8'h3c;
	localparam addr_t OFF_LVL_LO  = 8'h40;
	localparam addr_t OFF_LVL_HI  = 8'h44;

	// Values after reset
	localparam lines_t             IMR_RST  = 37'h00_0000_0000;
	localparam lines_t             EMR_RST  = 37'h00_0000_0000;
	localparam lines_t             RISE_RST = 37'h00_0000_0000;
	localparam lines_t             FALL_RST = 37'h00_0000_0000;
	localparam lines_t             PEND_RST = 37'h00_0000_0000;
	localparam logic [PSEL_W-1:0]  PSEL_RST = 7'h00;

	typedef struct packed {
		logic              cyc;
		logic              stb;
		logic              we;
		addr_t             adr;
		logic [3:0]        sel;
		logic [31:0]       dat;
	} wb_req_t;

	typedef struct packed {
		logic              ack;
		logic [31:0]       dat;
	} wb_rsp_t;

endpackage

/* File: rtl/edge_catch.sv */
`timescale 1ns/1ps
`default_nettype none

module edge_catch (
	input  wire logic clk_i,
	input  wire logic rst_i,
	input  wire logic pin_i,
	output var  logic rise_o,
	output var  logic fall_o,
	output var  logic level_o
);

	// Toggles clocked by the pin itself, so pulses narrower than clk_i are kept
	logic                          rtog_q = 1'b0;
	logic                          ftog_q = 1'b0;
	logic [eelc_pkg::SYNC_LEN-1:0] rsync_q = '0;
	logic [eelc_pkg::SYNC_LEN-1:0] fsync_q = '0;
	logic [1:0]                    lsync_q = '0;

	always_ff @(posedge pin_i) begin
		rtog_q <= ~rtog_q; // R5
	end

	always_ff @(negedge pin_i) begin
		ftog_q <= ~ftog_q; // R5
	end

	// Chains carry no reset; they settle on the toggles and the pin while reset is held
	always_ff @(posedge clk_i) begin
		rsync_q <= {rsync_q[eelc_pkg::SYNC_LEN-2:0], rtog_q};
		fsync_q <= {fsync_q[eelc_pkg::SYNC_LEN-2:0], ftog_q};
		lsync_q <= {lsync_q[0], pin_i};
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rise_o  <= 1'b0;
			fall_o  <= 1'b0;
			level_o <= 1'b0;
		end else begin
			rise_o  <= rsync_q[2] ^ rsync_q[1]; // R5
			fall_o  <= fsync_q[2] ^ fsync_q[1]; // R5
			level_o <= lsync_q[1];
		end
	end

endmodule

`default_nettype wire

/* File: sim/vic_model.sv */
`timescale 1ns/1ps
`default_nettype none

module vic_model (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire eelc_pkg::lines_t event_i,
	output var  int               ev_cnt_o
);
	// Counts per line, so two lines pulsing together count twice
	always_ff @(posedge clk_i) begin
		if (rst_i)
			ev_cnt_o <= 0;
		else
			ev_cnt_o <= ev_cnt_o + $countones(event_i);
	end
endmodule

`default_nettype wire

/* File: sim/edge_event_controller_properties.sv */
`timescale 1ns/1ps
`default_nettype none

module edge_event_controller_properties #(
	parameter int NUM_PINS = 83
) (
	input  wire logic                         clk_i,
	input  wire logic                         rst_i,
	input  wire eelc_pkg::wb_req_t            wb_i,
	input  wire eelc_pkg::wb_rsp_t            wb_o,
	input  wire logic [NUM_PINS-1:0]          pin_i,
	input  wire logic [eelc_pkg::NUM_INT-1:0] periph_i,
	input  wire eelc_pkg::lines_t             irq_req_o,
	input  wire eelc_pkg::lines_t             event_o,
	input  wire logic                         wakeup_o,
	input  wire logic                         irq_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);

	logic take;
	assign take = wb_i.cyc && wb_i.stb && !wb_o.ack;

	chk_ack_next: assert property (take |=> wb_o.ack)
		else $error("no ack after request");
	chk_ack_single: assert property (wb_o.ack |=> !wb_o.ack)
		else $error("ack longer than one cycle");
	chk_ack_unasked: assert property (!(wb_i.cyc && wb_i.stb) |=> !wb_o.ack)
		else $error("ack without request");
	chk_dat_idle: assert property (!wb_o.ack |-> wb_o.dat == 32'h0)
		else $error("read data outside ack");
	chk_irq_or: assert property (irq_o == (|irq_req_o))
		else $error("irq differs from line requests");
	chk_irq_sticky: assert property (irq_o && !(wb_i.cyc && wb_i.we) |=> irq_o)
		else $error("irq dropped without a write");
	chk_irq_woke: assert property ($rose(irq_o) |-> wakeup_o)
		else $error("irq rose without wakeup");
	chk_reset_quiet: assert property (@(posedge clk_i) disable iff (1'b0)
		rst_i |=> !irq_o && !wakeup_o && event_o == '0 && !wb_o.ack)
		else $error("outputs active after reset");

	cover property ($rose(irq_o));
	cover property (event_o != '0);
	cover property (wb_o.ack && wb_i.we);
endmodule

bind edge_event_controller edge_event_controller_properties #(.NUM_PINS(NUM_PINS)) props_i (
	.clk_i(clk_i), .rst_i(rst_i), .wb_i(wb_i), .wb_o(wb_o), .pin_i(pin_i),
	.periph_i(periph_i), .irq_req_o(irq_req_o), .event_o(event_o),
	.wakeup_o(wakeup_o), .irq_o(irq_o));

`default_nettype wire

/* File: sim/edge_event_controller_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module edge_event_controller_tb;
	logic              clk_i;
	logic              rst_i;
	eelc_pkg::wb_req_t req;
	eelc_pkg::wb_rsp_t rsp;
	logic [82:0]       pins;
	logic [20:0]       periph;
	eelc_pkg::lines_t  irq_req;
	eelc_pkg::lines_t  evt;
	logic              wake;
	logic              irq;
	int                ev_cnt;
	int                fail_count = 0;
	int                n_tests = 0;
	logic [31:0]       rd;

	edge_event_controller #(.NUM_PINS(83)) edge_event_controller_i (.clk_i(clk_i),
		.rst_i(rst_i), .wb_i(req), .wb_o(rsp), .pin_i(pins), .periph_i(periph),
		.irq_req_o(irq_req), .event_o(evt), .wakeup_o(wake), .irq_o(irq));
	vic_model vic_model_i (.clk_i(clk_i), .rst_i(rst_i), .event_i(evt), .ev_cnt_o(ev_cnt));

	initial begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// Holds the request until ack is sampled, then releases for a cycle
	task automatic wb(input logic we, input eelc_pkg::addr_t a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		req <= '{1'b1, 1'b1, we, a, 4'hf, d};
		do @(posedge clk_i); while (rsp.ack !== 1'b1 && n++ < 40);
		// A missing answer counts as a mismatch
		if (rsp.ack !== 1'b1)
			fail_count++;
		rd = rsp.dat;
		req <= '0;
	endtask

	task automatic settle();
		repeat (8) @(posedge clk_i);
	endtask

	task automatic t_reset();
		wb(1'b0, eelc_pkg::OFF_IMR_LO, 0);
		chk(rd, eelc_pkg::IMR_RST[31:0]);
		wb(1'b0, eelc_pkg::OFF_PEND_LO, 0);
		chk(rd, eelc_pkg::PEND_RST[31:0]);
		wb(1'b0, 8'hfc, 0);
		chk(rd, 0);
		chk(irq, 0);
	endtask

	// Line 0 sourced from pin 5, each trigger choice in turn
	task automatic t_edges();
		wb(1'b1, eelc_pkg::OFF_PSEL0, 32'h5);
		wb(1'b1, eelc_pkg::OFF_IMR_LO, 32'h1);
		wb(1'b1, eelc_pkg::OFF_EMR_LO, 32'h1);
		for (int m = 1; m < 4; m++) begin
			int e;
			e = ev_cnt;
			wb(1'b1, eelc_pkg::OFF_RISE_LO, m & 1);
			wb(1'b1, eelc_pkg::OFF_FALL_LO, m >> 1);
			@(posedge clk_i) pins[5] <= 1'b1;
			settle();
			chk(irq, m & 1);
			wb(1'b0, eelc_pkg::OFF_PEND_LO, 0);
			chk(rd, m & 1);
			wb(1'b1, eelc_pkg::OFF_PEND_LO, 32'h1);
			settle();
			chk(irq, 0);
			@(posedge clk_i) pins[5] <= 1'b0;
			settle();
			wb(1'b0, eelc_pkg::OFF_PEND_LO, 0);
			chk(rd, m >> 1);
			wb(1'b1, eelc_pkg::OFF_PEND_LO, 32'h1);
			chk(ev_cnt - e, (m & 1) + (m >> 1));
		end
	endtask

	// Pulse narrower than a clock period, between rising edges
	task automatic t_short();
		@(posedge clk_i);
		#2 pins[5] = 1'b1;
		#3 pins[5] = 1'b0;
		settle();
		wb(1'b0, eelc_pkg::OFF_PEND_LO, 0);
		chk(rd, 1);
		wb(1'b1, eelc_pkg::OFF_PEND_LO, 32'h1);
	endtask

	task automatic t_mask();
		int e;
		wb(1'b1, eelc_pkg::OFF_IMR_LO, 32'h1_0000);
		wb(1'b1, eelc_pkg::OFF_EMR_LO, 0);
		wb(1'b1, eelc_pkg::OFF_RISE_LO, 32'h1_0001);
		e = ev_cnt;
		@(posedge clk_i) pins[5] <= 1'b1;
		settle();
		wb(1'b0, eelc_pkg::OFF_PEND_LO, 0);
		chk(rd, 0);
		chk(ev_cnt - e, 0);
		@(posedge clk_i) periph[0] <= 1'b1;
		settle();
		chk(irq_req, 37'h1_0000);
		chk(irq, 1);
		chk(wake, 1);
		wb(1'b0, eelc_pkg::OFF_LVL_LO, 0);
		chk(rd, 32'h0001_0001);
		wb(1'b1, eelc_pkg::OFF_PEND_LO, 32'h1_0000);
		settle();
		chk(irq_req, 0);
		chk(wake, 0);
		wb(1'b1, eelc_pkg::OFF_SWT_LO, 32'h1_0000);
		settle();
		chk(irq_req, 37'h1_0000);
		wb(1'b1, eelc_pkg::OFF_PEND_LO, 32'h1_0000);
		settle();
		chk(irq, 0);
	endtask

	task automatic report_and_stop();
		$display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		req = '0;
		pins = '0;
		periph = '0;
		rst_i = 1'b1;
		repeat (4) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_edges();
		t_short();
		t_mask();
		report_and_stop();
	end

	// Scenarios need well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk_i);
		fail_count++;
		report_and_stop();
	end
endmodule

`default_nettype wire
